// File: include/epsc_pkg.sv
/*
  package for the exception pending state control block: register map,
  field positions, reset values and the carrier structs.
  assumes an APB slave with 32-bit data, one aligned word per register.
*/
package epsc_pkg;
  localparam logic [11:0] EPSC_ADDR_CTRL_STATE = 12'h004;
  localparam logic [11:0] EPSC_ADDR_RESET_CTRL = 12'h00c;
  localparam logic [11:0] EPSC_ADDR_IRQ_STATUS = 12'h010;
  localparam logic [11:0] EPSC_ADDR_IRQ_MASK = 12'h014;
  localparam int EPSC_NMI_SET_BIT = 31;
  localparam int EPSC_DSV_SET_BIT = 28;
  localparam int EPSC_DSV_CLR_BIT = 27;
  localparam int EPSC_TICK_SET_BIT = 26;
  localparam int EPSC_TICK_CLR_BIT = 25;
  localparam int EPSC_ANY_IRQ_BIT = 22;
  localparam int EPSC_TOP_LSB = 12;
  localparam int EPSC_CUR_LSB = 0;
  localparam int EPSC_NUM_W = 6;
  localparam int EPSC_KEY_LSB = 16;
  localparam logic [15:0] EPSC_WRITE_KEY = 16'h05fa;
  localparam int EPSC_ENDIAN_BIT = 15;
  localparam int EPSC_SYSRST_BIT = 2;
  localparam int EPSC_EVT_W = 4;
  localparam logic [3:0] EPSC_MASK_RESET = 4'h0;
  localparam logic [31:0] EPSC_ERR_DATA = 32'h0000_0000;

  // event bits: 0 nmi set, 1 deferred set, 2 tick set, 3 rejected key write
  typedef struct packed {
    logic nmi_pending;
    logic deferred_pending;
    logic tick_pending;
  } epsc_pend_t;

  typedef struct packed {
    logic any_irq_waiting;
    logic [5:0] top_waiting_number;
    logic [5:0] current_exception_number;
    logic nmi_handler_entry;
  } epsc_core_t;
endpackage : epsc_pkg

// File: core/epsc_flag.sv
/*
  one pending flag with set and clear pulses; set wins over clear.
  assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module epsc_flag (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_out
);
  logic next_flag;

  always_comb begin
    next_flag = flag_out;
    if (clr_in) begin
      next_flag = 1'b0;
    end
    // a set in the clear cycle is not lost
    if (set_in) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= next_flag;
    end
  end
endmodule : epsc_flag
`default_nettype wire

// File: core/epsc_ctrl.sv
/*
  exception pending state control: control and state register, reset
  control key check, sticky event status with mask and one interrupt.
  assumes an APB master on clk_in and prioritisation logic outside that
  supplies the pending and active numbers as synchronous inputs.
*/
// Chosen here: the APB register port and the register offsets.
// Notes on behaviour
// - writing one to bit 31 makes the non-maskable exception pending
// - entering the non-maskable handler clears its pending bit
// - bit 28 write one sets deferred-service pending, zero no effect
// - bit 28 reads the deferred-service pending state
// - only a software write of one pends the deferred-service exception
// - bit 27 write one clears deferred-service pending, write-only
// - bit 26 sets tick pending on one and reads its state
// - bit 25 write one clears tick pending, write-only
// - bit 22 reads one when any interrupt pends, excluding nmi and faults
// - bits 17 to 12 give top pending enabled exception number, else zero
// - bits 5 to 0 give active exception number, zero in thread mode
// - active number equals low six bits of status exception field
// - reset control ignores writes whose key is not 0x05fa
// - reset control reports endianness and requests system reset
`timescale 1ns/1ps
`default_nettype none
module epsc_ctrl
  import epsc_pkg::*;
#(
  parameter logic BIG_ENDIAN = 1'b0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire epsc_core_t core_in,
  output var epsc_pend_t pend_out,
  output logic sys_reset_req_out,
  output logic irq_out
);
  logic wr_access;
  logic rd_access;
  logic mapped;
  logic wr_ctrl;
  logic wr_reset;
  logic key_ok;
  logic nmi_set;
  logic dsv_set;
  logic dsv_clr;
  logic tick_set;
  logic tick_clr;
  logic nmi_flag;
  logic dsv_flag;
  logic tick_flag;
  logic [EPSC_EVT_W-1:0] evt;
  logic [EPSC_EVT_W-1:0] status;
  logic [EPSC_EVT_W-1:0] mask;
  logic [EPSC_EVT_W-1:0] next_status;
  logic [EPSC_EVT_W-1:0] next_mask;
  logic [31:0] ctrl_word;
  logic [31:0] rd_word;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_sysrst;
  logic next_irq;
  epsc_pend_t next_pend;

  // one wait state: the access cycle is answered on its second edge
  assign wr_access = psel_in && penable_in && !pready_out && pwrite_in;
  assign rd_access = psel_in && penable_in && !pready_out && !pwrite_in;
  assign mapped = (paddr_in == EPSC_ADDR_CTRL_STATE) || (paddr_in == EPSC_ADDR_RESET_CTRL) ||
                  (paddr_in == EPSC_ADDR_IRQ_STATUS) || (paddr_in == EPSC_ADDR_IRQ_MASK);
  assign wr_ctrl = wr_access && (paddr_in == EPSC_ADDR_CTRL_STATE);
  assign wr_reset = wr_access && (paddr_in == EPSC_ADDR_RESET_CTRL);
  assign key_ok = pwdata_in[EPSC_KEY_LSB +: 16] == EPSC_WRITE_KEY;

  // zero bits ignored; only these write strobes reach the flags
  assign nmi_set = wr_ctrl && pwdata_in[EPSC_NMI_SET_BIT];
  assign dsv_set = wr_ctrl && pwdata_in[EPSC_DSV_SET_BIT];
  assign dsv_clr = wr_ctrl && pwdata_in[EPSC_DSV_CLR_BIT];
  assign tick_set = wr_ctrl && pwdata_in[EPSC_TICK_SET_BIT];
  assign tick_clr = wr_ctrl && pwdata_in[EPSC_TICK_CLR_BIT];

  epsc_flag u_nmi (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .set_in(nmi_set),
    .clr_in(core_in.nmi_handler_entry),
    .flag_out(nmi_flag)
  );

  // both set and clear in one write: set wins, a legal pick for that case
  epsc_flag u_dsv (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .set_in(dsv_set),
    .clr_in(dsv_clr),
    .flag_out(dsv_flag)
  );

  epsc_flag u_tick (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .set_in(tick_set),
    .clr_in(tick_clr),
    .flag_out(tick_flag)
  );

  assign evt = {wr_reset && !key_ok, tick_set, dsv_set, nmi_set};

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[EPSC_NMI_SET_BIT] = nmi_flag;
    ctrl_word[EPSC_DSV_SET_BIT] = dsv_flag;
    ctrl_word[EPSC_TICK_SET_BIT] = tick_flag;
    // clear bits are write-only and read zero here
    ctrl_word[EPSC_TICK_CLR_BIT] = 1'b0;
    ctrl_word[EPSC_ANY_IRQ_BIT] = core_in.any_irq_waiting;
    ctrl_word[EPSC_TOP_LSB +: EPSC_NUM_W] = core_in.top_waiting_number;
    ctrl_word[EPSC_CUR_LSB +: EPSC_NUM_W] = core_in.current_exception_number;
  end

  always_comb begin
    rd_word = EPSC_ERR_DATA;
    case (paddr_in)
      EPSC_ADDR_CTRL_STATE: rd_word = ctrl_word;
      EPSC_ADDR_RESET_CTRL: begin
        rd_word[EPSC_ENDIAN_BIT] = BIG_ENDIAN;
      end
      EPSC_ADDR_IRQ_STATUS: rd_word[EPSC_EVT_W-1:0] = status;
      EPSC_ADDR_IRQ_MASK: rd_word[EPSC_EVT_W-1:0] = mask;
      default: rd_word = EPSC_ERR_DATA;
    endcase
  end

  always_comb begin
    next_pready = psel_in && penable_in && !pready_out;
    next_pslverr = next_pready && !mapped;
    next_prdata = prdata_out;
    if (rd_access) begin
      next_prdata = rd_word;
    end
    next_sysrst = wr_reset && key_ok && pwdata_in[EPSC_SYSRST_BIT];
    next_mask = mask;
    if (wr_access && paddr_in == EPSC_ADDR_IRQ_MASK) begin
      next_mask = pwdata_in[EPSC_EVT_W-1:0];
    end
    next_status = status;
    if (wr_access && paddr_in == EPSC_ADDR_IRQ_STATUS) begin
      next_status = status & ~pwdata_in[EPSC_EVT_W-1:0];
    end
    // new events win over a write-one clear in the same cycle
    next_status = next_status | evt;
    next_irq = |(next_status & next_mask);
    next_pend = '{nmi_pending: nmi_flag, deferred_pending: dsv_flag, tick_pending: tick_flag};
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      sys_reset_req_out <= 1'b0;
      status <= '0;
      mask <= EPSC_MASK_RESET;
      irq_out <= 1'b0;
      pend_out <= '0;
    end else begin
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      sys_reset_req_out <= next_sysrst;
      status <= next_status;
      mask <= next_mask;
      irq_out <= next_irq;
      pend_out <= next_pend;
    end
  end
endmodule : epsc_ctrl
`default_nettype wire

// File: test/epsc_ctrl_properties.sv
/* checker for epsc_ctrl ports: pending flags, read fields, write key.
   assumes one wait state per apb access and pend_out one cycle late. */
`timescale 1ns/1ps
`default_nettype none
module epsc_ctrl_properties
  import epsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire epsc_core_t core_in,
  input wire epsc_pend_t pend_out,
  input wire logic sys_reset_req_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // pready low marks the first access cycle, so each access counts once
  wire acc = psel_in && penable_in && !pready_out;
  wire wcs = acc && pwrite_in && paddr_in == EPSC_ADDR_CTRL_STATE;
  wire rcs = acc && !pwrite_in && paddr_in == EPSC_ADDR_CTRL_STATE;
  wire dsv_w = wcs && pwdata_in[EPSC_DSV_SET_BIT];
  wire wrst = acc && pwrite_in && paddr_in == EPSC_ADDR_RESET_CTRL;
  wire key_ok = pwdata_in[EPSC_KEY_LSB +: 16] == EPSC_WRITE_KEY;
  sequence s_ans;
    ##1 pready_out;
  endsequence
  property p_nmi_set;
    wcs && pwdata_in[EPSC_NMI_SET_BIT] |-> ##2 pend_out.nmi_pending;
  endproperty
  a_nmi_set: assert property (p_nmi_set) else $error("nmi not pending");
  property p_nmi_entry;
    core_in.nmi_handler_entry && !wcs |-> ##2 !pend_out.nmi_pending;
  endproperty
  a_nmi_entry: assert property (p_nmi_entry) else $error("nmi kept");
  property p_dsv_set;
    dsv_w |-> ##2 pend_out.deferred_pending;
  endproperty
  a_dsv_set: assert property (p_dsv_set) else $error("deferred not set");
  property p_dsv_clr;
    wcs && pwdata_in[EPSC_DSV_CLR_BIT] && !pwdata_in[EPSC_DSV_SET_BIT]
      |-> ##2 !pend_out.deferred_pending;
  endproperty
  a_dsv_clr: assert property (p_dsv_clr) else $error("deferred kept");
  property p_dsv_only;
    $rose(pend_out.deferred_pending) |-> $past(dsv_w, 2);
  endproperty
  a_dsv_only: assert property (p_dsv_only) else $error("deferred set alone");
  property p_tick_set;
    wcs && pwdata_in[EPSC_TICK_SET_BIT] |-> ##2 pend_out.tick_pending;
  endproperty
  a_tick_set: assert property (p_tick_set) else $error("tick not set");
  property p_tick_clr;
    wcs && pwdata_in[EPSC_TICK_CLR_BIT] && !pwdata_in[EPSC_TICK_SET_BIT]
      |-> ##2 !pend_out.tick_pending;
  endproperty
  a_tick_clr: assert property (p_tick_clr) else $error("tick kept");
  property p_fields;
    rcs |-> s_ans ##0 (prdata_out[EPSC_ANY_IRQ_BIT] == $past(core_in.any_irq_waiting)
      && prdata_out[EPSC_TOP_LSB +: EPSC_NUM_W] == $past(core_in.top_waiting_number)
      && prdata_out[EPSC_CUR_LSB +: EPSC_NUM_W] == $past(core_in.current_exception_number));
  endproperty
  a_fields: assert property (p_fields) else $error("core fields");
  // bit 25 is left out: its read value is not to be relied on
  property p_resv;
    rcs |-> s_ans ##0 (prdata_out & 32'h69bc_0fc0) == 32'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits");
  property p_key_bad;
    wrst && !key_ok |=> (!sys_reset_req_out) [*2];
  endproperty
  a_key_bad: assert property (p_key_bad) else $error("bad key taken");
  property p_key_good;
    wrst && key_ok && pwdata_in[EPSC_SYSRST_BIT] |=> sys_reset_req_out ##1 !sys_reset_req_out;
  endproperty
  a_key_good: assert property (p_key_good) else $error("keyed reset lost");
endmodule : epsc_ctrl_properties
bind epsc_ctrl epsc_ctrl_properties epsc_ctrl_properties_i (
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .prdata_out(prdata_out),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .core_in(core_in),
  .pend_out(pend_out),
  .sys_reset_req_out(sys_reset_req_out),
  .irq_out(irq_out)
);
`default_nettype wire

// File: test/test_exception_pending_state_control.sv
/* bench for epsc_ctrl: apb tasks and register sequences.
   assumes flags read back at once and irq one cycle after. */
`timescale 1ns/1ps
`default_nettype none
module test_exception_pending_state_control;
  import epsc_pkg::*;
  logic clk_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic sys_reset_req_out, irq_out, e;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, r;
  epsc_core_t core_in;
  epsc_pend_t pend_out;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_req = 0;
  epsc_ctrl epsc_ctrl_i (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .core_in(core_in),
    .pend_out(pend_out),
    .sys_reset_req_out(sys_reset_req_out),
    .irq_out(irq_out)
  );
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (sys_reset_req_out === 1'b1) n_req++;
  task automatic wrap_up;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    total_checks++;
    if (got !== x) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, x);
    end
  endtask : chk
  // idle edge first: psel is never dropped and raised in one step
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  endtask : xf
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xf(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd
  task automatic rc(input logic n, input logic d, input logic t);
    logic [31:0] x;
    xf(1'b0, EPSC_ADDR_CTRL_STATE, 32'h0);
    x = {n, 2'h0, d, 1'b0, t, 3'h0, core_in.any_irq_waiting, 4'h0,
      core_in.top_waiting_number, 6'h0, core_in.current_exception_number};
    // tick clear bit read value is not to be relied on, so it is masked
    chk(r & ~(32'h1 << EPSC_TICK_CLR_BIT), x);
  endtask : rc
  initial begin
    nrst_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    core_in = '0;
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    core_in <= {1'b1, 6'h2f, 6'h13, 1'b0};
    rd(EPSC_ADDR_IRQ_MASK, 32'h0);
    xf(1'b1, EPSC_ADDR_CTRL_STATE, 32'h0);
    rc(1'b0, 1'b0, 1'b0);
    chk({26'h0, r[5:0] - 6'h10}, 32'h3);
    // sets only: set and clear of one exception never go together
    xf(1'b1, EPSC_ADDR_CTRL_STATE, 32'hf5ff_ffff);
    rc(1'b1, 1'b1, 1'b1);
    chk({29'h0, pend_out}, 32'h7);
    xf(1'b1, EPSC_ADDR_CTRL_STATE, 32'h0800_0000);
    rc(1'b1, 1'b0, 1'b1);
    xf(1'b1, EPSC_ADDR_CTRL_STATE, 32'h0200_0000);
    rc(1'b1, 1'b0, 1'b0);
    core_in.nmi_handler_entry <= 1'b1;
    @(posedge clk_in);
    core_in <= '0;
    rc(1'b0, 1'b0, 1'b0);
    rd(12'h008, 32'h0);
    chk({31'h0, e}, 32'h1);
    rd(EPSC_ADDR_IRQ_STATUS, 32'h7);
    chk({31'h0, irq_out}, 32'h0);
    xf(1'b1, EPSC_ADDR_IRQ_MASK, 32'hf);
    @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h1);
    xf(1'b1, EPSC_ADDR_IRQ_STATUS, 32'h7);
    @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    xf(1'b1, EPSC_ADDR_RESET_CTRL, 32'h05fb_0004);
    rd(EPSC_ADDR_IRQ_STATUS, 32'h8);
    chk({31'h0, irq_out}, 32'h1);
    chk(n_req, 32'h0);
    xf(1'b1, EPSC_ADDR_RESET_CTRL, 32'h05fa_0004);
    repeat (2) @(posedge clk_in);
    chk(n_req, 32'h1);
    rd(EPSC_ADDR_RESET_CTRL, 32'h0);
    wrap_up();
  end
endmodule : test_exception_pending_state_control
`default_nettype wire
